// File: verification/hbd_chk_sva.sv
`timescale 1ns/1ps
module hbd_chk import hbd_pkg::*; (
    input wire logic ref_clk_in, sys_rst_in, if_parallel_in, data_command_select_in, busy_in,
    input wire logic chip_select_low_active_n_in, chip_select_high_active_in,
    input wire logic serial_data_out, serial_clk_out,
    input wire logic bus_style_select_in, rd_strobe_n_in, wr_strobe_n_in,
    input wire logic [7:0] bus_data_in, bus_data_out, bus_data_oe_out, ram_rdata_in,
    input wire logic [6:0] status_low_in,
    input hbd_access_s access_out,
    input hbd_level_e indicator_common_out_a_out, indicator_common_out_b_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    wire logic on = !chip_select_low_active_n_in && chip_select_high_active_in && if_parallel_in;
    wire logic any = access_out.data_wr || access_out.cmd_wr || access_out.data_rd;
    wire logic oe = bus_data_oe_out[0];
    wire logic rd_pins = bus_style_select_in ? (rd_strobe_n_in && wr_strobe_n_in)
                                             : (!rd_strobe_n_in && wr_strobe_n_in);
    sequence s_rd(d); oe && data_command_select_in == d ##1 oe; endsequence
    a_idle_no_drive: assert property (!on |-> bus_data_oe_out == 8'h00)
        else $error("bus driven while idle");
    a_serial_pins: assert property ({serial_data_out, serial_clk_out} == bus_data_in[7:6])
        else $error("serial pin map");
    a_indicator_pair: assert property (indicator_common_out_a_out == indicator_common_out_b_out)
        else $error("indicator outputs differ");
    a_ram_read: assert property (s_rd(1'b1) |-> bus_data_out == $past(ram_rdata_in))
        else $error("read byte not ram data");
    a_status_busy: assert property (s_rd(1'b0) |-> bus_data_out[7] == $past(busy_in))
        else $error("busy bit wrong");
    a_status_low: assert property (s_rd(1'b0) |-> bus_data_out[6:0] == $past(status_low_in))
        else $error("status bits wrong");
    a_unsel_quiet: assert property ((!on)[*8] |-> !any)
        else $error("pulse while unselected");
    a_pulse_single: assert property (any |=> !any)
        else $error("access pulse too long");
    a_read_drive: assert property (on && rd_pins |-> bus_data_oe_out == 8'hFF)
        else $error("read access not driven");
endmodule // hbd_chk

bind hbd_host_bus_mode_decode hbd_chk i_hbd_chk (.*);

// File: verification/hbd_host_model.sv
`timescale 1ns/1ps
module hbd_host_model (
    input wire logic clk_in,
    input wire logic [7:0] d_in,
    output logic par_out, sty_out, csn_out, dc_out, rd_out, wr_out,
    output logic [7:0] d_out
);
    initial {par_out, sty_out, csn_out, dc_out, rd_out, wr_out, d_out} = 14'h2F00;
    task automatic acc(input logic s, w, dc, input logic [7:0] v, output logic [7:0] q);
        @(negedge clk_in) {sty_out, rd_out, wr_out} = {s, !s, 1'b1};
        repeat (4) @(negedge clk_in);
        {csn_out, dc_out, wr_out, d_out} = {1'b0, dc, !(s & w), ~v};
        repeat (4) @(negedge clk_in);
        if (s) rd_out = 1'b1;
        else if (w) wr_out = 1'b0;
        else rd_out = 1'b0;
        repeat (2) @(negedge clk_in);
        // Byte settles late, so an early capture is caught
        d_out = w ? v : 8'h5A;
        repeat (2) @(negedge clk_in);
        q = d_in;
        {rd_out, wr_out, d_out} = {!s, !(s & w), ~d_out};
        repeat (4) @(negedge clk_in);
        {csn_out, wr_out} = 2'b11;
    endtask
    // Serial mode: strobes and style stay at their last fixed levels
    task automatic ser(input logic [1:0] b);
        @(negedge clk_in) {par_out, csn_out, d_out} = {2'b00, b, 6'h2A};
    endtask
endmodule // hbd_host_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import hbd_pkg::*;
    logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, chip_select_high_active_in = 1'b1, busy_in = 1'b1;
    logic scan_data_in = 1'b0, frame_polarity_in = 1'b0, power_save_in = 1'b0, indicator_in = 1'b0;
    logic if_parallel_in, bus_style_select_in, chip_select_low_active_n_in, data_command_select_in;
    logic rd_strobe_n_in, wr_strobe_n_in, serial_data_out, serial_clk_out, serial_active_out;
    logic [7:0] ram_rdata_in = 8'hA5, bus_data_out, bus_data_oe_out, hd, q;
    logic [6:0] status_low_in = 7'h2A;
    wire logic [7:0] bus_data_in = (bus_data_oe_out & bus_data_out) | (~bus_data_oe_out & hd);
    hbd_access_s access_out;
    hbd_level_e common_row_out, indicator_common_out_a_out, indicator_common_out_b_out;
    hbd_level_e lv [4] = '{HBD_LVL_V4, HBD_LVL_V1, HBD_LVL_VDD, HBD_LVL_V5};
    int bad_count = 0, total_checks = 0, nw = 0, nc = 0, nr = 0, cyc = 0;
    always #12.5 ref_clk_in = ~ref_clk_in;
    hbd_host_bus_mode_decode i_hbd_host_bus_mode_decode (.*);
    hbd_host_model i_hbd_host_model (.clk_in(ref_clk_in), .d_in(bus_data_in),
        .par_out(if_parallel_in), .sty_out(bus_style_select_in),
        .csn_out(chip_select_low_active_n_in), .dc_out(data_command_select_in),
        .rd_out(rd_strobe_n_in), .wr_out(wr_strobe_n_in), .d_out(hd));
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        nw <= nw + access_out.data_wr;
        nc <= nc + access_out.cmd_wr;
        nr <= nr + access_out.data_rd;
        if (cyc == 3000) bad_count++;
        if (cyc == 3000) report_and_stop;
    end
    task automatic chk(input string n, input logic [7:0] s, x);
        total_checks++;
        if (s !== x) bad_count++;
        if (s !== x) $display("[ERR] %s exp %h seen %h", n, x, s);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_write;
        for (int i = 0; i < 4; i++) begin
            i_hbd_host_model.acc(i[1], 1'b1, i[0], 8'h3C + i[7:0], q);
            repeat (3) @(negedge ref_clk_in);
            chk("wdata", access_out.wdata, 8'h3C + i[7:0]);
        end
        chk("writes", {nw[3:0], nc[3:0]}, 8'h22);
    endtask
    task automatic t_read;
        for (int i = 0; i < 2; i++) begin
            i_hbd_host_model.acc(i[0], 1'b0, 1'b1, 8'h00, q);
            i_hbd_host_model.acc(i[0], 1'b0, 1'b1, 8'h00, q);
            chk("ram", q, ram_rdata_in);
            i_hbd_host_model.acc(i[0], 1'b0, 1'b0, 8'h00, q);
            chk("status", q, {busy_in, status_low_in});
        end
        chk("reads", nr[7:0], 8'h04);
    endtask
    task automatic t_com;
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk_in) {power_save_in, scan_data_in, frame_polarity_in} = i[2:0];
            indicator_in = i[1];
            #1 chk("com", {common_row_out, indicator_common_out_a_out, indicator_common_out_b_out},
                {3{i[2] ? HBD_LVL_VDD : lv[i[1:0]]}});
        end
    endtask
    task automatic t_serial;
        for (int i = 0; i < 4; i++) begin
            i_hbd_host_model.ser(i[1:0]);
            repeat (6) @(negedge ref_clk_in);
            chk("serial", {serial_data_out, serial_clk_out, serial_active_out}, {i[1:0], 1'b1});
        end
    endtask
    initial begin
        repeat (6) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        repeat (4) @(negedge ref_clk_in);
        t_write;
        t_read;
        t_com;
        t_serial;
        report_and_stop;
    end
endmodule // tb_top

// File: verilog/hbd_host_bus_mode_decode.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Strap high selects the parallel byte bus, strap low the serial input.
// - In serial mode bit 7 is serial data, bit 6 serial clock, bits 5..0 stay undriven.
// - Bus style select high means 6800 style (E, R/W), low means 8080 style.
// - A parallel read with data/command select at 1 returns display RAM data.
// - A parallel write with data/command select at 1 stores a display data byte.
// - A parallel read with data/command select at 0 returns the status byte.
// - A parallel write with data/command select at 0 is passed on as a command byte.
// - Common outputs pick V5, VDD, V1 or V4 from scan data (indicator outputs: indicator input) and frame polarity; VDD in power save.
// - Both indicator common outputs always carry the same signal.
// - With chip select inactive the bus is undriven and no access pulse is given; a write strobe still loads access_out.wdata.
// - A status read shows the busy flag on bit 7.
module hbd_host_bus_mode_decode (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Straps
    input wire logic if_parallel_in,
    input wire logic bus_style_select_in,
    // Host bus controls
    input wire logic chip_select_low_active_n_in,
    input wire logic chip_select_high_active_in,
    input wire logic data_command_select_in,
    input wire logic rd_strobe_n_in,
    input wire logic wr_strobe_n_in,
    // Byte bus pins
    input wire logic [7:0] bus_data_in,
    output logic [7:0] bus_data_out,
    output logic [7:0] bus_data_oe_out,
    // Core side
    input wire logic [7:0] ram_rdata_in,
    input wire logic [6:0] status_low_in,
    input wire logic busy_in,
    output hbd_pkg::hbd_access_s access_out,
    output logic serial_data_out,
    output logic serial_clk_out,
    output logic serial_active_out,
    // Display drive
    input wire logic scan_data_in,
    input wire logic frame_polarity_in,
    input wire logic power_save_in,
    input wire logic indicator_in,
    output hbd_pkg::hbd_level_e common_row_out,
    output hbd_pkg::hbd_level_e indicator_common_out_a_out,
    output hbd_pkg::hbd_level_e indicator_common_out_b_out
);
    import hbd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, change taken when stages 2 and 3 agree

    logic [2:0] sy_rd_q, sy_rd_d;
    logic [2:0] sy_wr_q, sy_wr_d;
    logic [2:0] sy_sel_q, sy_sel_d;
    logic [2:0] sy_dc_q, sy_dc_d;
    // Byte bus delayed alongside the strobes so each sample lines up with its strobe;
    // no glitch filter needed, a sample only counts while its strobe is seen active
    logic [2:0][7:0] sy_data_q, sy_data_d;
    logic rd_n_q, rd_n_d;
    logic wr_n_q, wr_n_d;
    logic sel_q, sel_d;
    logic dc_q, dc_d;
    logic chip_sel;
    logic style_6800;

    function automatic logic filt(input logic [2:0] s, input logic prev);
        filt = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    // Combined chip select pin level; both must be asserted
    assign chip_sel = ~chip_select_low_active_n_in & chip_select_high_active_in;
    // Style strap is static, so it is used without a synchroniser
    assign style_6800 = (bus_style_select_in == STYLE_6800);

    always_comb begin
        sy_rd_d = {sy_rd_q[1:0], rd_strobe_n_in};
        sy_wr_d = {sy_wr_q[1:0], wr_strobe_n_in};
        sy_sel_d = {sy_sel_q[1:0], chip_sel};
        sy_dc_d = {sy_dc_q[1:0], data_command_select_in};
        sy_data_d = {sy_data_q[1:0], bus_data_in};
        rd_n_d = filt(sy_rd_q, rd_n_q);
        wr_n_d = filt(sy_wr_q, wr_n_q);
        sel_d = filt(sy_sel_q, sel_q);
        dc_d = filt(sy_dc_q, dc_q);
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            // Strobes start at their 8080 idle level; select starts off, which masks
            // the one false E edge that a 6800 host would otherwise cause after reset
            sy_rd_q <= SYNC_IDLE_HI;
            sy_wr_q <= SYNC_IDLE_HI;
            sy_sel_q <= SYNC_RST;
            sy_dc_q <= SYNC_RST;
            sy_data_q <= {3{BYTE_RST}};
            rd_n_q <= LVL_HI;
            wr_n_q <= LVL_HI;
            sel_q <= LVL_LO;
            dc_q <= LVL_LO;
        end else begin
            sy_rd_q <= sy_rd_d;
            sy_wr_q <= sy_wr_d;
            sy_sel_q <= sy_sel_d;
            sy_dc_q <= sy_dc_d;
            sy_data_q <= sy_data_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            sel_q <= sel_d;
            dc_q <= dc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access decode on the synchronised strobes

    logic [7:0] wdata_q, wdata_d;
    hbd_access_s acc_q, acc_d;
    logic wr_taking;
    logic wr_end;
    logic rd_end;

    // Third stage marks samples taken while the write was active; the filtered
    // level lags past the host's data hold time, so it cannot qualify the data
    assign wr_taking = style_6800 ? (sy_rd_q[2] & ~sy_wr_q[2]) : ~sy_wr_q[2];
    // 6800 style ends on E falling; 8080 style on the strobe rising
    assign wr_end = style_6800 ? (rd_n_q & ~rd_n_d & ~wr_n_q) : (~wr_n_q & wr_n_d);
    assign rd_end = style_6800 ? (rd_n_q & ~rd_n_d & wr_n_q) : (~rd_n_q & rd_n_d);

    always_comb begin
        // Last sample before the strobe ends is the one that counts
        wdata_d = wdata_q;
        if (wr_taking) begin
            wdata_d = sy_data_q[2];
        end
        acc_d = '0;
        acc_d.wdata = wdata_q;
        // Pulses only while selected in parallel mode
        if (sel_q && if_parallel_in == MODE_PARALLEL) begin
            if (wr_end) begin
                acc_d.data_wr = dc_q;
                acc_d.cmd_wr = ~dc_q;
            end
            // Status reads give no pulse; they change nothing in the core
            if (rd_end) begin
                acc_d.data_rd = dc_q;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            wdata_q <= BYTE_RST;
            acc_q <= '0;
        end else begin
            wdata_q <= wdata_d;
            acc_q <= acc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read byte register

    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        // Busy sits on bit 7 of the status byte
        rdata_d = dc_q ? ram_rdata_in : {busy_in, status_low_in};
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rdata_q <= BYTE_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus drive: read data in parallel mode only; serial mode never drives

    logic is_read;

    // Bus drive is combinational on the pin levels so the host sees data inside its strobe;
    // the byte itself lags a select change by five cycles, so the host sets it up first
    // 6800 style reads with E high and R/W high, 8080 style with read low and write high
    assign is_read = style_6800 ? (rd_strobe_n_in & wr_strobe_n_in)
                                : (~rd_strobe_n_in & wr_strobe_n_in);
    assign bus_data_out = rdata_q;
    assign bus_data_oe_out = (chip_sel && if_parallel_in == MODE_PARALLEL && is_read)
                           ? 8'hFF : 8'h00;
    assign access_out = acc_q;

    // Serial pins handed on raw; the shifter resynchronises them
    assign serial_data_out = bus_data_in[BIT_SERIAL_DATA];
    assign serial_clk_out = bus_data_in[BIT_SERIAL_CLK];
    assign serial_active_out = (if_parallel_in != MODE_PARALLEL) & sel_q;

    ////////////////////////////////////////////////////////////////////////////
    // Common drive level select

    function automatic hbd_level_e com_level(input logic scan, input logic fr, input logic ps);
        // Power save overrides the scan and polarity table
        if (ps) begin
            com_level = HBD_LVL_VDD;
        end else begin
            unique case ({scan, fr})
                2'b11: com_level = HBD_LVL_V5;
                2'b10: com_level = HBD_LVL_VDD;
                2'b01: com_level = HBD_LVL_V1;
                2'b00: com_level = HBD_LVL_V4;
            endcase
        end
    endfunction

    assign common_row_out = com_level(scan_data_in, frame_polarity_in, power_save_in);
    // One source feeds both indicator terminals
    assign indicator_common_out_a_out = com_level(indicator_in, frame_polarity_in,
                                                  power_save_in);
    assign indicator_common_out_b_out = indicator_common_out_a_out;

endmodule // hbd_host_bus_mode_decode

// File: verilog/hbd_pkg.sv
package hbd_pkg;

    // Bus style and interface selection strap levels
    localparam logic MODE_PARALLEL = 1'b1;
    localparam logic STYLE_6800 = 1'b1;

    // Byte bus bit positions
    localparam int BIT_SERIAL_DATA = 7;
    localparam int BIT_SERIAL_CLK = 6;
    localparam int BIT_BUSY = 7;

    // Reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [2:0] SYNC_RST = 3'h0;
    localparam logic [2:0] SYNC_IDLE_HI = 3'h7;
    localparam logic LVL_HI = 1'h1;
    localparam logic LVL_LO = 1'h0;

    // Common output drive level select
    typedef enum logic [1:0] {
        HBD_LVL_VDD,
        HBD_LVL_V1,
        HBD_LVL_V4,
        HBD_LVL_V5
    } hbd_level_e;

    // Decoded access strobe to the core
    typedef struct packed {
        logic data_wr;
        logic cmd_wr;
        logic data_rd;
        logic [7:0] wdata;
    } hbd_access_s;

endpackage
